/* File: verification/adcsc_host.sv */
`timescale 1ns/1ps
// ------------------------------
// Host serial port model
// ------------------------------
module adcsc_host (
    // Serial port
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    task automatic xfer(input logic [15:0] f, output logic [15:0] r);
        cs_n_o = 1'b0;
        #40;
        for (int i = 15; i >= 0; i--) begin
            sdi_o = f[i];
            #32 sclk_o = 1'b1;
            r = {r[14:0], sdo_i};
            #32 sclk_o = 1'b0;
        end
        #32 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #40;
    endtask : xfer
endmodule : adcsc_host

/* File: verification/adcsc_sva.sv */
`timescale 1ns/1ps
// ------------------------------
// Converter control checks
// ------------------------------
module adcsc_sva (
    // Clock and reset
    input wire logic                  clk_i,
    input wire logic                  resetn_i,
    // Converter side
    input wire logic                  sample_done_i,
    input wire adcsc_pkg::adcsc_cfg_s cfg_o,
    input wire logic                  conv_start_o,
    input wire logic                  mux_advance_o
);
    import adcsc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_mux_follow: assert property (sample_done_i && cfg_o.delay_mux |=> mux_advance_o)
        else $error("mux advance missing");
    a_mux_cause: assert property (mux_advance_o |-> $past(sample_done_i))
        else $error("mux advance without sampling end");
    a_start_gate: assert property (conv_start_o |-> !cfg_o.power_down && !cfg_o.conv_idle)
        else $error("start while idle or powered down");
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse too long");
    a_idle_manual: assert property (cfg_o.conv_idle |-> !(cfg_o.auto_trigger || cfg_o.delay_mux))
        else $error("idle mode with active modes");
    a_auto_delay: assert property (cfg_o.auto_trigger && !cfg_o.auto_channel |-> cfg_o.delay_mux)
        else $error("auto manual mode without delayed mux");
    a_scan_auto: assert property (cfg_o.auto_channel |-> cfg_o.auto_trigger && !cfg_o.delay_mux)
        else $error("auto channel without auto trigger");
    a_multi_chan: assert property (cfg_o.multi_scan |-> cfg_o.auto_channel)
        else $error("multi scan without auto channel");
    cover property (conv_start_o);
    cover property (mux_advance_o);
    cover property (cfg_o.multi_scan);
endmodule : adcsc_sva
bind adcsc_top adcsc_sva chk_u (.*);

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
    import adcsc_pkg::*;
    logic        clk_i, resetn_i, sclk_i, cs_n_i, sdi_i, sdo_o, sdo_oe_o, busy_i;
    logic        conversion_start_pin_i, result_valid_i, scan_done_i, sample_done_i;
    logic [11:0] result_data_i;
    adcsc_cfg_s  cfg_o;
    logic        conv_start_o, mux_advance_o, busy_int_o;
    logic [15:0] r;
    logic [7:0]  d;
    int          errors, comparisons, cyc, starts, hi, oe;
    adcsc_top dut_u (.*);
    adcsc_host host_u (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i), .sdo_i(sdo_o));
    always @(posedge sclk_i) oe += sdo_oe_o;
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        starts += conv_start_o;
        hi += (busy_int_o === 1'b1);
        if (cyc == 40000) begin
            errors++;
            summarize();
        end
    end
    // ------------------------------
    // Helpers
    // ------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic clks(input int n);
        repeat (n) @(negedge clk_i);
    endtask : clks
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        host_u.xfer({CMD_REG_WR, a, 2'h0, v}, r);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        host_u.xfer({CMD_REG_RD, a, 2'h0, 8'h00}, r);
        d = r[7:0];
    endtask : rd
    task automatic pls();
        clks(1);
        result_valid_i = 1'b1;
        clks(1);
        result_valid_i = 1'b0;
    endtask : pls
    task automatic kick(input int e);
        int s0;
        s0 = starts;
        clks(1);
        conversion_start_pin_i = 1'b1;
        clks(3);
        conversion_start_pin_i = 1'b0;
        clks(10);
        chk(starts - s0, e);
    endtask : kick
    // ------------------------------
    // Scenarios
    // ------------------------------
    // trigger codes
    task automatic t_trig();
        logic [2:0] e;
        e = TRIG_RST;
        oe = 0;
        rd(ADDR_TRIG);
        chk(oe, 15);
        chk(d, {5'h00, e});
        for (int c = 0; c < 8; c++) begin
            if (c != 1 && c != 7) e = 3'(c);
            wr(ADDR_TRIG, 8'(c));
            clks(1);
            sample_done_i = 1'b1;
            scan_done_i = 1'b1;
            clks(1);
            sample_done_i = 1'b0;
            scan_done_i = 1'b0;
            chk(mux_advance_o, e inside {3, 4});
            chk({cfg_o.conv_idle, cfg_o.auto_trigger, cfg_o.auto_channel, cfg_o.multi_scan},
                {e == 0, e inside {4, 5, 6}, e inside {5, 6}, e == 6});
            rd(ADDR_TRIG);
            chk(d, {5'h00, e});
        end
        wr(ADDR_TRIG, 8'h00);
        rd(4'hB);
        chk(d, 8'h00);
        rd(ADDR_STATUS);
        chk(d, 8'h02);
    endtask : t_trig
    task automatic t_avg();
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_SETUP, {3'(c), 5'h02});
            rd(ADDR_SETUP);
            chk(d, {3'(c), 5'h02});
            chk({cfg_o.avg_kind, cfg_o.avg_count_code, cfg_o.fifo_en},
                {c[1:0] == 0 ? AVG_OFF : c[2] ? AVG_ACCURATE : AVG_FAST, c[1:0], 1'b1});
        end
    endtask : t_avg
    task automatic t_fifo();
        wr(ADDR_IRQ, 8'h0C);
        repeat (9) pls();
        rd(ADDR_STATUS);
        chk(d, 8'h8F);
        rd(ADDR_IRQ);
        chk(d, 8'h0C);
        chk(busy_int_o, 1'b0);
        host_u.xfer({CMD_ADC_RD, 14'h0000}, r);
        chk(r, {4'h0, result_data_i});
        rd(ADDR_STATUS);
        chk(d, 8'h78);
        wr(ADDR_SETUP, 8'h00);
        rd(ADDR_STATUS);
        chk(d, 8'h00);
        chk(busy_int_o, 1'b1);
    endtask : t_fifo
    task automatic t_start();
        int s0;
        wr(ADDR_SETUP, 8'h01);
        wr(ADDR_TRIG, 8'h02);
        s0 = starts;
        host_u.xfer({CMD_ADC_RD, 14'h0000}, r);
        chk(starts - s0, 1);
        wr(ADDR_TRIG, 8'h00);
        wr(ADDR_SETUP, 8'h00);
        wr(ADDR_IRQ, 8'h80);
        wr(ADDR_TRIG, 8'h02);
        kick(0);
        wr(ADDR_TRIG, 8'h00);
        rd(ADDR_IRQ);
        chk(d, 8'h80);
        chk({cfg_o.power_down, cfg_o.read_starts_conversion}, 2'b10);
        wr(ADDR_IRQ, 8'h00);
        wr(ADDR_TRIG, 8'h02);
        kick(1);
        wr(ADDR_TRIG, 8'h00);
    endtask : t_start
    task automatic t_pin();
        wr(ADDR_SETUP, 8'h18);
        host_u.xfer({CMD_ADC_RD, 14'h0000}, r);
        wr(ADDR_IRQ, 8'h01);
        clks(2);
        hi = 0;
        pls();
        clks(70);
        chk(hi, IRQ_PULSE_CYC);
        wr(ADDR_SETUP, 8'h0C);
        clks(1);
        busy_i = 1'b1;
        clks(4);
        chk(busy_int_o, 1'b1);
        busy_i = 1'b0;
        clks(4);
        chk(busy_int_o, 1'b0);
    endtask : t_pin
    task automatic summarize();
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    initial begin
        {resetn_i, busy_i, conversion_start_pin_i, result_valid_i, scan_done_i, sample_done_i} = '0;
        result_data_i = 12'hA5C;
        clks(20);
        resetn_i = 1'b1;
        clks(4);
        t_trig();
        t_avg();
        t_fifo();
        t_start();
        t_pin();
        summarize();
    end
endmodule : tb

/* File: verilog/adcsc_pkg.sv */
package adcsc_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_MHZ   = 200;
    localparam int unsigned IRQ_PULSE_NS   = 250;
    localparam int unsigned IRQ_PULSE_CYC  = (IRQ_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int unsigned FRAME_BITS     = 16;
    localparam logic [4:0]  CNT_CMD_LAST   = 5'h01;
    localparam logic [4:0]  CNT_ADDR_LAST  = 5'h05;
    localparam logic [4:0]  CNT_DATA_FIRST = 5'h06;
    localparam logic [4:0]  CNT_FRAME_LAST = 5'h0F;
    localparam logic [1:0]  CMD_REG_RD     = 2'h1;
    localparam logic [1:0]  CMD_REG_WR     = 2'h2;
    localparam logic [1:0]  CMD_ADC_RD     = 2'h3;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_SETUP     = 4'h5;
    localparam logic [3:0]  ADDR_IRQ       = 4'h6;
    localparam logic [3:0]  ADDR_STATUS    = 4'h7;
    localparam logic [3:0]  ADDR_TRIG      = 4'h8;
    localparam logic [7:0]  SETUP_RST      = 8'h00;
    localparam logic [4:0]  IRQ_RST        = 5'h00;
    localparam logic [2:0]  TRIG_RST       = 3'h2;

    // Setup register fields
    localparam int unsigned SET_AVG_LSB    = 5;
    localparam int unsigned SET_SHAPE      = 4;
    localparam int unsigned SET_POL        = 3;
    localparam int unsigned SET_FUNC       = 2;
    localparam int unsigned SET_FIFO       = 1;
    localparam int unsigned SET_SRC        = 0;
    // Interrupt register fields
    localparam int unsigned IRQ_PD         = 7;
    localparam int unsigned IRQ_NE         = 3;
    localparam int unsigned IRQ_FULL       = 2;
    localparam int unsigned IRQ_SCAN       = 1;
    localparam int unsigned IRQ_DRDY       = 0;
    localparam int unsigned IRQ_EN_W       = 4;

    // Averaging codes
    localparam logic [2:0]  AVG_NONE_A     = 3'h0;
    localparam logic [2:0]  AVG_NONE_B     = 3'h4;

    // Trigger codes
    localparam logic [2:0]  TRIG_IDLE      = 3'h0;
    localparam logic [2:0]  TRIG_RSV_A     = 3'h1;
    localparam logic [2:0]  TRIG_MAN       = 3'h2;
    localparam logic [2:0]  TRIG_MAN_DLY   = 3'h3;
    localparam logic [2:0]  TRIG_AUTO_MAN  = 3'h4;
    localparam logic [2:0]  TRIG_AUTO_ONE  = 3'h5;
    localparam logic [2:0]  TRIG_AUTO_MULT = 3'h6;
    localparam logic [2:0]  TRIG_RSV_B     = 3'h7;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AVG_OFF,
        AVG_FAST,
        AVG_ACCURATE
    } adcsc_avg_e;

    typedef struct packed {
        adcsc_avg_e avg_kind;
        logic [1:0] avg_count_code;
        logic       fifo_en;
        logic       read_starts_conversion;
        logic       power_down;
        logic       conv_idle;
        logic       auto_trigger;
        logic       auto_channel;
        logic       multi_scan;
        logic       delay_mux;
    } adcsc_cfg_s;

    typedef struct packed {
        logic [1:0] cmd;
        logic [3:0] addr;
        logic [7:0] data;
    } adcsc_frame_s;

endpackage : adcsc_pkg

/* File: verilog/adcsc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R1: Averaging code picks none, fast or accurate
// R2: Interrupt pin level, or 250ns edge pulse
// R3: Polarity bit: clear low, set high active
// R4: Function bit: clear interrupt, set busy
// R5: Buffer enable bit gates result FIFO storage
// R6: Start source: pin, or each result read
// R7: Top interrupt bit selects power-down idle
// R8: Not-empty interrupt enable and raised flag
// R9: Full interrupt enable and raised flag
// R10: Scan-ready interrupt, auto channel trigger only
// R11: Result-ready interrupt; all enables reset zero
// R12: Status upper nibble gives FIFO entry count
// R13: Status bit 3 means FIFO not empty
// R14: Status bit 2 means FIFO full
// R15: Status bits 1,0: scan, result ready
// R16: Trigger 000 idle, 010 default, reserved codes
// R17: Trigger 011 manual with delayed mux
// R18: Trigger 100 auto trigger, delayed mux on
// R19: Trigger 101 auto channel, single scan
// R20: Trigger 110 auto channel, multi scan
// R21: Host touches most registers only when idle; the code accepts register writes in every trigger mode
// R22: Delayed mux advances after sampling completes
// R23: FIFO eight deep, full at eight
module adcsc_top #(
    parameter int unsigned FIFO_DEPTH  = 8,
    parameter int unsigned RESULT_BITS = 12
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    // Serial port
    input  wire logic                   sclk_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   sdi_i,
    output logic                        sdo_o,
    output logic                        sdo_oe_o,
    // Conversion start pin
    input  wire logic                   conversion_start_pin_i,
    // Converter events
    input  wire logic                   result_valid_i,
    input  wire logic [RESULT_BITS-1:0] result_data_i,
    input  wire logic                   scan_done_i,
    input  wire logic                   sample_done_i,
    input  wire logic                   busy_i,
    // Converter control
    output adcsc_pkg::adcsc_cfg_s       cfg_o,
    output logic                        conv_start_o,
    output logic                        mux_advance_o,
    output logic                        busy_int_o
);
    import adcsc_pkg::*;

    localparam int unsigned LVL_W = $clog2(FIFO_DEPTH + 1);
    localparam int unsigned PLS_W = $clog2(IRQ_PULSE_CYC + 1);
    localparam logic [LVL_W-1:0] LVL_FULL  = LVL_W'(FIFO_DEPTH);
    localparam logic [PLS_W-1:0] PLS_LOAD  = PLS_W'(IRQ_PULSE_CYC);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic trig_is_reserved(input logic [2:0] code);
        trig_is_reserved = (code == TRIG_RSV_A) || (code == TRIG_RSV_B);
    endfunction : trig_is_reserved

    function automatic logic trig_is_auto_chan(input logic [2:0] code);
        trig_is_auto_chan = (code == TRIG_AUTO_ONE) || (code == TRIG_AUTO_MULT);
    endfunction : trig_is_auto_chan

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                   cs_meta_reg, cs_sync_reg;
    logic                   cp_meta_reg, cp_sync_reg, cp_prev_reg;
    logic                   wr_meta_reg, wr_sync_reg, wr_seen_reg;
    logic                   rd_meta_reg, rd_sync_reg, rd_seen_reg;
    logic [7:0]             setup_reg;
    logic [IRQ_EN_W:0]      irq_reg;
    logic [2:0]             trig_reg;
    logic [LVL_W-1:0]       level_reg, level_next;
    logic                   drdy_reg, scan_reg;
    logic [RESULT_BITS-1:0] result_reg;
    logic                   int_prev_reg;
    logic [PLS_W-1:0]       pulse_reg, pulse_next;
    logic                   pin_reg;
    logic                   start_reg, mux_reg;
    adcsc_cfg_s             cfg_reg, cfg_next;
    logic [7:0]             snap_setup_reg, snap_irq_reg, snap_status_reg, snap_trig_reg;
    logic [RESULT_BITS-1:0] snap_result_reg;
    // Serial clock domain
    logic [4:0]             bit_cnt_reg;
    logic [FRAME_BITS-1:0]  in_shift_reg;
    logic [1:0]             cmd_reg;
    logic [3:0]             addr_reg;
    logic                   sdo_reg, sdo_oe_reg;
    adcsc_frame_s           hold_reg;
    logic                   wr_tgl_reg, rd_tgl_reg;

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire logic       frame_busy  = ~cs_sync_reg;
    wire logic       pin_rise    = cp_sync_reg & ~cp_prev_reg;
    wire logic       wr_evt      = wr_sync_reg ^ wr_seen_reg;
    wire logic       rd_evt      = rd_sync_reg ^ rd_seen_reg;
    wire logic       wr_setup    = wr_evt && (hold_reg.addr == ADDR_SETUP);
    wire logic       wr_irq      = wr_evt && (hold_reg.addr == ADDR_IRQ);
    wire logic       wr_trig     = wr_evt && (hold_reg.addr == ADDR_TRIG)
                                   && !trig_is_reserved(hold_reg.data[2:0]);
    wire logic       fifo_en     = setup_reg[SET_FIFO];
    wire logic       not_empty   = (level_reg != '0);
    wire logic       is_full     = (level_reg == LVL_FULL);
    // R5: storing gated by enable
    wire logic       push        = result_valid_i && fifo_en && !is_full;
    wire logic       pop         = rd_evt && not_empty;
    // R8 R9 R10 R11: raised when enabled and true
    wire logic [3:0] irq_raised  = irq_reg[IRQ_EN_W-1:0] & {not_empty, is_full, scan_reg, drdy_reg};
    wire logic       int_level   = |irq_raised;
    wire logic       int_rise    = int_level & ~int_prev_reg;
    wire logic       running     = !irq_reg[IRQ_EN_W] && (trig_reg != TRIG_IDLE);
    // R6: start from pin or from result read
    wire logic       start_evt   = running && (setup_reg[SET_SRC] ? rd_evt : pin_rise);
    // R2: level or fixed pulse
    wire logic       int_shaped  = setup_reg[SET_SHAPE] ? (pulse_next != '0) : int_level;
    // R4: interrupt or busy on shared pin
    wire logic       pin_active  = setup_reg[SET_FUNC] ? busy_i : int_shaped;

    // R2: pulse timer on rising interrupt
    always_comb begin
        pulse_next = pulse_reg;
        if (int_rise) begin
            pulse_next = PLS_LOAD;
        end else if (pulse_reg != '0) begin
            pulse_next = pulse_reg - PLS_W'(1);
        end
    end

    // R12: FIFO occupancy
    always_comb begin
        level_next = level_reg;
        if (!fifo_en) begin
            level_next = '0;
        end else if (push && !pop) begin
            level_next = level_reg + LVL_W'(1);
        end else if (pop && !push) begin
            level_next = level_reg - LVL_W'(1);
        end
    end

    always_comb begin
        cfg_next = '0;
        // R1: averaging kind and count
        if ((setup_reg[7:SET_AVG_LSB] == AVG_NONE_A) || (setup_reg[7:SET_AVG_LSB] == AVG_NONE_B)) begin
            cfg_next.avg_kind = AVG_OFF;
        end else if (setup_reg[7]) begin
            cfg_next.avg_kind = AVG_ACCURATE;
        end else begin
            cfg_next.avg_kind = AVG_FAST;
        end
        cfg_next.avg_count_code         = setup_reg[6:SET_AVG_LSB];
        cfg_next.fifo_en                = fifo_en;
        cfg_next.read_starts_conversion = setup_reg[SET_SRC];
        // R7: power-down idle
        cfg_next.power_down             = irq_reg[IRQ_EN_W];
        cfg_next.conv_idle              = 1'b0;
        cfg_next.auto_trigger           = 1'b0;
        cfg_next.auto_channel           = 1'b0;
        cfg_next.multi_scan             = 1'b0;
        cfg_next.delay_mux              = 1'b0;
        case (trig_reg)
            // R16: idle and manual modes
            TRIG_IDLE: begin
                cfg_next.conv_idle = 1'b1;
            end
            TRIG_MAN: begin
                cfg_next.conv_idle = 1'b0;
            end
            // R17: manual with delayed mux
            TRIG_MAN_DLY: begin
                cfg_next.delay_mux = 1'b1;
            end
            // R18: auto trigger, delayed mux
            TRIG_AUTO_MAN: begin
                cfg_next.auto_trigger = 1'b1;
                cfg_next.delay_mux    = 1'b1;
            end
            // R19: single scan pass
            TRIG_AUTO_ONE: begin
                cfg_next.auto_trigger = 1'b1;
                cfg_next.auto_channel = 1'b1;
            end
            // R20: repeated scans
            TRIG_AUTO_MULT: begin
                cfg_next.auto_trigger = 1'b1;
                cfg_next.auto_channel = 1'b1;
                cfg_next.multi_scan   = 1'b1;
            end
            default: begin
                cfg_next.conv_idle = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cp_meta_reg <= 1'b0;
            cp_sync_reg <= 1'b0;
            cp_prev_reg <= 1'b0;
        end else begin
            cs_meta_reg <= cs_n_i;
            cs_sync_reg <= cs_meta_reg;
            cp_meta_reg <= conversion_start_pin_i;
            cp_sync_reg <= cp_meta_reg;
            cp_prev_reg <= cp_sync_reg;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_meta_reg <= 1'b0;
            wr_sync_reg <= 1'b0;
            wr_seen_reg <= 1'b0;
            rd_meta_reg <= 1'b0;
            rd_sync_reg <= 1'b0;
            rd_seen_reg <= 1'b0;
        end else begin
            wr_meta_reg <= wr_tgl_reg;
            wr_sync_reg <= wr_meta_reg;
            wr_seen_reg <= wr_sync_reg;
            rd_meta_reg <= rd_tgl_reg;
            rd_sync_reg <= rd_meta_reg;
            rd_seen_reg <= rd_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            setup_reg <= SETUP_RST;
            irq_reg   <= IRQ_RST;
            trig_reg  <= TRIG_RST;
        end else begin
            if (wr_setup) begin
                setup_reg <= hold_reg.data;
            end
            // R7 R8 R9 R10 R11: enables and power-down
            if (wr_irq) begin
                irq_reg <= {hold_reg.data[IRQ_PD], hold_reg.data[IRQ_EN_W-1:0]};
            end
            // R16: reserved codes leave mode alone
            if (wr_trig) begin
                trig_reg <= hold_reg.data[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Status and result tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            level_reg  <= '0;
            drdy_reg   <= 1'b0;
            scan_reg   <= 1'b0;
            result_reg <= '0;
        end else begin
            // R23: count saturates at depth
            level_reg <= level_next;
            // R15: ready flags, set beats clear
            drdy_reg  <= result_valid_i || (drdy_reg && !rd_evt);
            // R10: scan ready in auto channel only
            scan_reg  <= (scan_done_i && trig_is_auto_chan(trig_reg)) || (scan_reg && !rd_evt);
            if (result_valid_i) begin
                result_reg <= result_data_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Pins and converter controls
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            int_prev_reg <= 1'b0;
            pulse_reg    <= '0;
            pin_reg      <= 1'b1;
            start_reg    <= 1'b0;
            mux_reg      <= 1'b0;
            cfg_reg      <= '0;
        end else begin
            int_prev_reg <= int_level;
            pulse_reg    <= pulse_next;
            // R3: polarity of shared pin
            pin_reg      <= setup_reg[SET_POL] ? pin_active : ~pin_active;
            start_reg    <= start_evt;
            // R22: advance mux after sampling
            mux_reg      <= sample_done_i && cfg_reg.delay_mux;
            cfg_reg      <= cfg_next;
        end
    end

    // ------------------------------------------------------------
    // Read image, frozen while a frame is open
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            snap_setup_reg  <= '0;
            snap_irq_reg    <= '0;
            snap_status_reg <= '0;
            snap_trig_reg   <= '0;
            snap_result_reg <= '0;
        end else if (!frame_busy) begin
            snap_setup_reg  <= setup_reg;
            snap_irq_reg    <= {irq_reg[IRQ_EN_W], 3'h0, irq_raised};
            // R12 R13 R14 R15: status layout
            snap_status_reg <= {4'(level_reg), not_empty, is_full, scan_reg, drdy_reg};
            snap_trig_reg   <= {5'h00, trig_reg};
            snap_result_reg <= result_reg;
        end
    end

    // ------------------------------------------------------------
    // Serial port, serial clock domain
    // ------------------------------------------------------------
    wire logic       frame_rst_n = resetn_i & ~cs_n_i;
    wire logic [3:0] out_idx     = 4'hF - bit_cnt_reg[3:0];
    wire logic [7:0] rd_byte     = (addr_reg == ADDR_SETUP)  ? snap_setup_reg  :
                                   (addr_reg == ADDR_IRQ)    ? snap_irq_reg    :
                                   (addr_reg == ADDR_STATUS) ? snap_status_reg :
                                   (addr_reg == ADDR_TRIG)   ? snap_trig_reg   : 8'h00;
    wire logic [FRAME_BITS-1:0] out_word =
        (cmd_reg == CMD_ADC_RD) ? FRAME_BITS'(snap_result_reg) :
        ((cmd_reg == CMD_REG_RD) && (bit_cnt_reg >= CNT_DATA_FIRST)) ? FRAME_BITS'(rd_byte) : '0;
    wire logic       frame_end   = (bit_cnt_reg == CNT_FRAME_LAST);

    always_ff @(posedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_reg  <= '0;
            in_shift_reg <= '0;
            cmd_reg      <= '0;
            addr_reg     <= '0;
        end else begin
            if (bit_cnt_reg <= CNT_FRAME_LAST) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
            in_shift_reg <= {in_shift_reg[FRAME_BITS-2:0], sdi_i};
            if (bit_cnt_reg == CNT_CMD_LAST) begin
                cmd_reg <= {in_shift_reg[0], sdi_i};
            end
            if (bit_cnt_reg == CNT_ADDR_LAST) begin
                addr_reg <= {in_shift_reg[2:0], sdi_i};
            end
        end
    end

    always_ff @(negedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            sdo_reg    <= 1'b0;
            sdo_oe_reg <= 1'b0;
        end else begin
            sdo_oe_reg <= 1'b1;
            if ((bit_cnt_reg != '0) && (bit_cnt_reg <= CNT_FRAME_LAST)) begin
                sdo_reg <= out_word[out_idx];
            end else begin
                sdo_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge sclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_reg   <= '0;
            wr_tgl_reg <= 1'b0;
            rd_tgl_reg <= 1'b0;
        end else if (frame_end && !cs_n_i) begin
            if (cmd_reg == CMD_REG_WR) begin
                hold_reg   <= '{cmd: cmd_reg, addr: addr_reg, data: {in_shift_reg[6:0], sdi_i}};
                wr_tgl_reg <= ~wr_tgl_reg;
            end
            // R6: each result read can start next
            if (cmd_reg == CMD_ADC_RD) begin
                rd_tgl_reg <= ~rd_tgl_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sdo_o         = sdo_reg;
    assign sdo_oe_o      = sdo_oe_reg;
    assign cfg_o         = cfg_reg;
    assign conv_start_o  = start_reg;
    assign mux_advance_o = mux_reg;
    assign busy_int_o    = pin_reg;

endmodule : adcsc_top
